//--- rtl/vie_instruction_executor.sv
// Instruction executor of a 20x2 dot-matrix display controller.
// Assumes host pins synchronous to CLOCK and a static interface strap.
//
// The placing of the registers and the plain strobed port were chosen for this implementation.
`timescale 1ns/10ps
module vie_instruction_executor
    import vie_pkg::*;
(
    // Clock and reset.
    input wire logic CLOCK,
    input wire logic RST,
    // Static interface strap.
    input wire logic [1:0] MODE_STRAP,
    // Parallel host pins.
    input wire logic CMD_DATA_SELECT,
    input wire logic RW_OR_WRITE_N,
    input wire logic ENABLE_OR_READ_N,
    input wire logic [7:0] DATA_IN,
    output logic [7:0] DATA_OUT,
    output logic DATA_OE,
    // Serial host pins.
    input wire logic SERIAL_STROBE_N,
    input wire logic SERIAL_CLOCK,
    input wire logic SERIAL_IN,
    output logic SERIAL_OUT,
    output logic SERIAL_OE,
    // Settings toward the display drive.
    output logic BUS_WIDTH_8,
    output logic LINES_TWO,
    output logic [1:0] LUMINANCE,
    output logic DISPLAY_ON,
    output logic CURSOR_ON,
    output logic BLINK_ON,
    output logic INCREMENT,
    output logic SHIFT_ENABLE,
    output logic [6:0] SHIFT_OFFSET,
    output logic [6:0] CURSOR_ADDRESS,
    output logic GLYPH_TARGET,
    // Display scan ports.
    input wire logic [6:0] CHAR_SCAN_ADDR,
    output logic [7:0] CHAR_SCAN_DATA,
    input wire logic [5:0] GLYPH_SCAN_ADDR,
    output logic [7:0] GLYPH_SCAN_DATA
);

    vie_mode_e mode;
    logic strap_taken;
    logic [6:0] address_counter;
    logic glyph_target;
    logic bus_width_bit;
    logic increment;
    logic shift_enable;
    logic [6:0] shift_offset;
    logic prev_rw;
    logic prev_en;
    logic par_rd_begin;
    logic par_rd_end;
    logic par_wr_done;
    logic par_rd_active;
    logic phase_low;
    logic [3:0] held_hi;
    logic [7:0] read_hold;
    logic par_rd_cd;
    logic par_req;
    logic ser_req;
    logic ser_cd;
    logic ser_rw;
    logic [7:0] ser_data;
    logic sel_cd;
    logic [7:0] mem_rdata;
    logic [7:0] rd_value;
    logic req;
    logic req_cd;
    logic req_rw;
    logic [7:0] req_data;
    vie_instr_e kind;
    logic cmd_write;
    logic data_write;
    logic data_read;

    // Steps the counter one place; glyph addresses wrap within six bits.
    function automatic logic [6:0] step_ctr(input logic [6:0] a, input logic up,
                                            input logic glyph);
        logic [6:0] n;
        n = up ? a + 7'h01 : a - 7'h01;
        if (glyph) begin
            n[6] = 1'b0;
        end
        return n;
    endfunction : step_ctr

    // The strap is caught once, at the first edge after reset release,
    // so a strap that wanders later cannot switch styles mid-transfer.
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            mode <= MODE_RW_ENABLE;
            strap_taken <= 1'b0;
        end else if (!strap_taken) begin
            strap_taken <= 1'b1;
            if (MODE_STRAP == STRAP_SERIAL) begin
                mode <= MODE_SERIAL;
            end else if (MODE_STRAP == STRAP_WR_RD) begin
                mode <= MODE_WR_RD;
            end else begin
                mode <= MODE_RW_ENABLE;
            end
        end
    end

    // Previous pin levels for edge detection.
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            prev_rw <= 1'b1;
            prev_en <= 1'b0;
        end else begin
            prev_rw <= RW_OR_WRITE_N;
            prev_en <= ENABLE_OR_READ_N;
        end
    end

    // Strobe events of the two parallel styles.
    always_comb begin
        par_rd_begin = 1'b0;
        par_rd_end = 1'b0;
        par_wr_done = 1'b0;
        par_rd_active = 1'b0;
        if (!strap_taken || mode == MODE_SERIAL) begin
            par_rd_active = 1'b0;
        end else if (mode == MODE_WR_RD) begin
            par_rd_begin = !ENABLE_OR_READ_N && prev_en;
            par_rd_end = ENABLE_OR_READ_N && !prev_en;
            par_wr_done = RW_OR_WRITE_N && !prev_rw;
            par_rd_active = !ENABLE_OR_READ_N;
        end else begin
            // Direction is taken as it stood while the enable was high.
            par_rd_begin = ENABLE_OR_READ_N && !prev_en && RW_OR_WRITE_N;
            par_rd_end = !ENABLE_OR_READ_N && prev_en && prev_rw;
            par_wr_done = !ENABLE_OR_READ_N && prev_en && !prev_rw;
            par_rd_active = ENABLE_OR_READ_N && RW_OR_WRITE_N;
        end
    end

    // Nibble phase; every transfer on the narrow bus toggles it.
    always_ff @(posedge CLOCK) begin
        if (RST || bus_width_bit) begin
            phase_low <= 1'b0;
        end else if (par_wr_done || par_rd_end) begin
            phase_low <= !phase_low;
        end
    end

    // High nibble of a narrow write waits for its low half.
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            held_hi <= 4'h0;
        end else if (par_wr_done && !phase_low) begin
            held_hi <= DATA_IN[7:4];
        end
    end

    // Read byte is frozen at the first strobe so both nibbles match.
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            read_hold <= 8'h00;
            par_rd_cd <= 1'b0;
            DATA_OUT <= 8'h00;
        end else if (par_rd_begin) begin
            if (bus_width_bit) begin
                read_hold <= rd_value;
                par_rd_cd <= CMD_DATA_SELECT;
                DATA_OUT <= rd_value;
            end else if (!phase_low) begin
                read_hold <= rd_value;
                par_rd_cd <= CMD_DATA_SELECT;
                DATA_OUT <= {rd_value[7:4], 4'h0};
            end else begin
                DATA_OUT <= {read_hold[3:0], 4'h0};
            end
        end
    end

    // Output enable is registered to line up with the data.
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            DATA_OE <= 1'b0;
        end else begin
            DATA_OE <= par_rd_active;
        end
    end

    vie_serial u_serial (
        .clk(CLOCK),
        .rst(RST),
        .enable(strap_taken && mode == MODE_SERIAL),
        .strobe_n(SERIAL_STROBE_N),
        .sck(SERIAL_CLOCK),
        .sdi(SERIAL_IN),
        .sdo(SERIAL_OUT),
        .sdo_oe(SERIAL_OE),
        .rd_value(rd_value),
        .req(ser_req),
        .req_cd(ser_cd),
        .req_rw(ser_rw),
        .req_data(ser_data)
    );

    // Read answer: memory byte, or status with a busy flag that is never set.
    assign sel_cd = (mode == MODE_SERIAL) ? ser_cd : CMD_DATA_SELECT;
    assign rd_value = sel_cd ? mem_rdata : {BUSY_FLAG_VALUE, address_counter};

    // Completed transfers from whichever port the strap chose; no stall exists.
    assign par_req = (par_wr_done || par_rd_end) && (bus_width_bit || phase_low);
    always_comb begin
        if (mode == MODE_SERIAL) begin
            req = ser_req;
            req_cd = ser_cd;
            req_rw = ser_rw;
            req_data = ser_data;
        end else begin
            req = par_req;
            req_cd = par_rd_end ? par_rd_cd : CMD_DATA_SELECT;
            req_rw = par_rd_end;
            req_data = bus_width_bit ? DATA_IN : {held_hi, DATA_IN[7:4]};
        end
    end

    assign kind = instr_kind(req_data);
    assign cmd_write = req && !req_cd && !req_rw;
    assign data_write = req && req_cd && !req_rw;
    assign data_read = req && req_cd && req_rw;

    vie_mem u_mem (
        .clk(CLOCK),
        .rst(RST),
        .clear(cmd_write && kind == INSTR_CLEAR),
        .we(data_write),
        .glyph_sel(glyph_target),
        .addr(address_counter),
        .wdata(req_data),
        .rdata(mem_rdata),
        .scan_addr(CHAR_SCAN_ADDR),
        .scan_data(CHAR_SCAN_DATA),
        .glyph_scan_addr(GLYPH_SCAN_ADDR),
        .glyph_scan_data(GLYPH_SCAN_DATA)
    );

    // Function settings; nothing else is touched by this instruction.
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            bus_width_bit <= BUS8_RESET;
            LINES_TWO <= LINES2_RESET;
            LUMINANCE <= LUM_RESET;
        end else if (cmd_write && kind == INSTR_FUNCTION) begin
            bus_width_bit <= req_data[FS_WIDTH_BIT];
            LINES_TWO <= req_data[FS_LINES_BIT];
            LUMINANCE <= {req_data[FS_LUM_HI_BIT], req_data[FS_LUM_LO_BIT]};
        end
    end

    // Entry mode; clear also forces the increment direction.
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            increment <= INC_RESET;
            shift_enable <= SHIFT_EN_RESET;
        end else if (cmd_write && kind == INSTR_ENTRY) begin
            increment <= req_data[ENTRY_DIR_BIT];
            shift_enable <= req_data[ENTRY_SHIFT_BIT];
        end else if (cmd_write && kind == INSTR_CLEAR) begin
            increment <= INC_RESET;
        end
    end

    // Display, cursor and blink switches.
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            DISPLAY_ON <= DISPLAY_RESET;
            CURSOR_ON <= CURSOR_RESET;
            BLINK_ON <= BLINK_RESET;
        end else if (cmd_write && kind == INSTR_DISPLAY) begin
            DISPLAY_ON <= req_data[DISP_ON_BIT];
            CURSOR_ON <= req_data[DISP_CURSOR_BIT];
            BLINK_ON <= req_data[DISP_BLINK_BIT];
        end
    end

    // Address counter and memory target; a status read leaves both alone.
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            address_counter <= CTR_RESET;
            glyph_target <= 1'b0;
        end else if (cmd_write) begin
            case (kind)
                INSTR_CLEAR, INSTR_HOME: begin
                    address_counter <= CTR_RESET;
                    glyph_target <= 1'b0;
                end
                INSTR_GLYPH_ADDR: begin
                    address_counter <= {1'b0, req_data[5:0]};
                    glyph_target <= 1'b1;
                end
                INSTR_CHAR_ADDR: begin
                    address_counter <= req_data[6:0];
                    glyph_target <= 1'b0;
                end
                INSTR_SHIFT: begin
                    address_counter <= step_ctr(address_counter, req_data[RL_BIT], 1'b0);
                    glyph_target <= 1'b0;
                end
                default: begin
                    address_counter <= address_counter;
                end
            endcase
        end else if (data_write || data_read) begin
            // Reads rely on the host having set the address beforehand.
            address_counter <= step_ctr(address_counter, increment,
                                        glyph_target);
        end
    end

    // Display shift offset; character writes and the shift instruction move it, reads never do.
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            shift_offset <= OFFSET_RESET;
        end else if (cmd_write && (kind == INSTR_CLEAR || kind == INSTR_HOME)) begin
            shift_offset <= OFFSET_RESET;
        end else if (cmd_write && kind == INSTR_SHIFT && req_data[SC_BIT]) begin
            shift_offset <= req_data[RL_BIT] ? shift_offset - 7'h01 : shift_offset + 7'h01;
        end else if (data_write && !glyph_target && shift_enable) begin
            if (increment) begin
                shift_offset <= shift_offset + 7'h01;
            end else begin
                shift_offset <= shift_offset - 7'h01;
            end
        end
    end

    // Settings shown to the display drive.
    assign BUS_WIDTH_8 = bus_width_bit;
    assign INCREMENT = increment;
    assign SHIFT_ENABLE = shift_enable;
    assign SHIFT_OFFSET = shift_offset;
    assign CURSOR_ADDRESS = address_counter;
    assign GLYPH_TARGET = glyph_target;

endmodule : vie_instruction_executor

//--- rtl/vie_pkg.sv
// Shared constants, types and decode helpers of the display instruction executor.
// Assumes one 250 MHz clock and a synchronous, active-high reset.
package vie_pkg;

    // Widths and memory depths.
    localparam int CTR_W = 7;
    localparam int GLYPH_AW = 6;
    localparam int CHAR_DEPTH = 128;
    localparam int GLYPH_DEPTH = 64;

    // Values after reset and fixed answer values.
    localparam logic [7:0] SPACE_CODE = 8'h20;
    localparam logic [6:0] CTR_RESET = 7'h00;
    localparam logic [6:0] OFFSET_RESET = 7'h00;
    localparam logic BUS8_RESET = 1'b1;
    localparam logic LINES2_RESET = 1'b1;
    localparam logic [1:0] LUM_RESET = 2'h0;
    localparam logic INC_RESET = 1'b1;
    localparam logic SHIFT_EN_RESET = 1'b0;
    localparam logic DISPLAY_RESET = 1'b0;
    localparam logic CURSOR_RESET = 1'b0;
    localparam logic BLINK_RESET = 1'b0;
    localparam logic BUSY_FLAG_VALUE = 1'b0;

    // Instruction field positions.
    localparam int CHAR_SET_BIT = 7;
    localparam int GLYPH_SET_BIT = 6;
    localparam int FUNC_SET_BIT = 5;
    localparam int SHIFT_SET_BIT = 4;
    localparam int DISP_SET_BIT = 3;
    localparam int ENTRY_SET_BIT = 2;
    localparam int HOME_SET_BIT = 1;
    localparam int CLEAR_SET_BIT = 0;
    localparam int FS_WIDTH_BIT = 4;
    localparam int FS_LINES_BIT = 3;
    localparam int FS_LUM_HI_BIT = 1;
    localparam int FS_LUM_LO_BIT = 0;
    localparam int ENTRY_DIR_BIT = 1;
    localparam int ENTRY_SHIFT_BIT = 0;
    localparam int DISP_ON_BIT = 2;
    localparam int DISP_CURSOR_BIT = 1;
    localparam int DISP_BLINK_BIT = 0;
    localparam int SC_BIT = 3;
    localparam int RL_BIT = 2;

    // Strap codes; any other code selects the read/write-plus-enable style.
    localparam logic [1:0] STRAP_WR_RD = 2'h1;
    localparam logic [1:0] STRAP_SERIAL = 2'h2;

    // Serial frame bit counts: select bit, direction bit, then eight data bits.
    localparam logic [3:0] SER_CD_CNT = 4'h0;
    localparam logic [3:0] SER_RW_CNT = 4'h1;
    localparam logic [3:0] SER_LAST_CNT = 4'h9;

    typedef enum {MODE_RW_ENABLE, MODE_WR_RD, MODE_SERIAL} vie_mode_e;

    typedef enum {
        INSTR_NONE, INSTR_CLEAR, INSTR_HOME, INSTR_ENTRY, INSTR_DISPLAY,
        INSTR_SHIFT, INSTR_FUNCTION, INSTR_GLYPH_ADDR, INSTR_CHAR_ADDR
    } vie_instr_e;

    // The highest set bit of an instruction byte names the instruction.
    function automatic vie_instr_e instr_kind(input logic [7:0] d);
        if (d[CHAR_SET_BIT]) begin
            return INSTR_CHAR_ADDR;
        end else if (d[GLYPH_SET_BIT]) begin
            return INSTR_GLYPH_ADDR;
        end else if (d[FUNC_SET_BIT]) begin
            return INSTR_FUNCTION;
        end else if (d[SHIFT_SET_BIT]) begin
            return INSTR_SHIFT;
        end else if (d[DISP_SET_BIT]) begin
            return INSTR_DISPLAY;
        end else if (d[ENTRY_SET_BIT]) begin
            return INSTR_ENTRY;
        end else if (d[HOME_SET_BIT]) begin
            return INSTR_HOME;
        end else if (d[CLEAR_SET_BIT]) begin
            return INSTR_CLEAR;
        end
        return INSTR_NONE;
    endfunction : instr_kind

endpackage : vie_pkg

//--- rtl/vie_mem.sv
// Character code memory and glyph memory with host port and scan ports.
// Assumes the executor gives at most one write per cycle.
`timescale 1ns/10ps
module vie_mem
    import vie_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Host side.
    input wire logic clear,
    input wire logic we,
    input wire logic glyph_sel,
    input wire logic [6:0] addr,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata,
    // Display scan side.
    input wire logic [6:0] scan_addr,
    output logic [7:0] scan_data,
    input wire logic [5:0] glyph_scan_addr,
    output logic [7:0] glyph_scan_data
);

    logic [7:0] chars [CHAR_DEPTH];
    logic [7:0] glyphs [GLYPH_DEPTH];

    // Reset and clear fill every character cell with a space in one cycle,
    // which costs a wide reset fan-out but keeps the host free of waits.
    always_ff @(posedge clk) begin
        if (rst || clear) begin
            for (int i = 0; i < CHAR_DEPTH; i++) begin
                chars[i] <= SPACE_CODE;
            end
        end else if (we && !glyph_sel) begin
            chars[addr] <= wdata;
        end
    end

    // Glyph memory keeps its contents through reset.
    always_ff @(posedge clk) begin
        if (we && glyph_sel) begin
            glyphs[addr[5:0]] <= wdata;
        end
    end

    // The host read is combinational so a read answers in its own cycle.
    assign rdata = glyph_sel ? glyphs[addr[5:0]] : chars[addr];

    // Scan reads are registered.
    always_ff @(posedge clk) begin
        scan_data <= chars[scan_addr];
        glyph_scan_data <= glyphs[glyph_scan_addr];
    end

endmodule : vie_mem

//--- rtl/vie_serial.sv
// Synchronous serial host port: frame of select bit, direction bit, data byte.
// Assumes strobe and serial clock are synchronous to clk and far slower.
`timescale 1ns/10ps
module vie_serial
    import vie_pkg::*;
(
    // Clock, reset and enable.
    input wire logic clk,
    input wire logic rst,
    input wire logic enable,
    // Serial pins.
    input wire logic strobe_n,
    input wire logic sck,
    input wire logic sdi,
    output logic sdo,
    output logic sdo_oe,
    // Toward the executor.
    input wire logic [7:0] rd_value,
    output logic req,
    output logic req_cd,
    output logic req_rw,
    output logic [7:0] req_data
);

    logic prev_sck;
    logic [3:0] cnt;
    logic [7:0] shift;
    logic sck_rise;
    logic sck_fall;
    logic active;

    assign active = enable && !strobe_n;
    assign sck_rise = active && sck && !prev_sck;
    assign sck_fall = active && !sck && prev_sck;

    always_ff @(posedge clk) begin
        if (rst) begin
            prev_sck <= 1'b1;
        end else begin
            prev_sck <= sck;
        end
    end

    // Frame sequencing; a strobe released early abandons the frame.
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt <= 4'h0;
            req_cd <= 1'b0;
            req_rw <= 1'b0;
            shift <= 8'h00;
            req <= 1'b0;
            req_data <= 8'h00;
            sdo <= 1'b0;
            sdo_oe <= 1'b0;
        end else begin
            req <= 1'b0;
            if (!active) begin
                cnt <= 4'h0;
                sdo_oe <= 1'b0;
            end else if (sck_rise) begin
                if (cnt != SER_LAST_CNT) begin
                    cnt <= cnt + 4'h1;
                end else begin
                    cnt <= SER_CD_CNT;
                    req <= 1'b1;
                    req_data <= {shift[6:0], sdi};
                end
                if (cnt == SER_CD_CNT) begin
                    req_cd <= sdi;
                end else if (cnt == SER_RW_CNT) begin
                    req_rw <= sdi;
                    // Read value is picked with the select bit taken one edge earlier.
                    if (sdi) begin
                        shift <= rd_value;
                        sdo_oe <= 1'b1;
                    end
                end else if (!req_rw) begin
                    shift <= {shift[6:0], sdi};
                end
                if (cnt == SER_LAST_CNT) begin
                    sdo_oe <= 1'b0;
                end
            end else if (sck_fall && req_rw && sdo_oe) begin
                sdo <= shift[7];
                shift <= {shift[6:0], 1'b0};
            end
        end
    end

endmodule : vie_serial

//--- verification/vie_executor_asserts.sv
// Checker of the executor's top ports for the read/write-plus-enable style.
// Assumes MODE_STRAP selects that style and a bind from the bench.
`timescale 1ns/10ps
module vie_executor_asserts
    import vie_pkg::*;
(
    // Clock, reset and host pins.
    input wire logic CLOCK,
    input wire logic RST,
    input wire logic CMD_DATA_SELECT,
    input wire logic RW_OR_WRITE_N,
    input wire logic ENABLE_OR_READ_N,
    input wire logic [7:0] DATA_IN,
    input wire logic [7:0] DATA_OUT,
    input wire logic DATA_OE,
    // Settings.
    input wire logic BUS_WIDTH_8,
    input wire logic LINES_TWO,
    input wire logic [1:0] LUMINANCE,
    input wire logic INCREMENT,
    input wire logic SHIFT_ENABLE,
    input wire logic [6:0] SHIFT_OFFSET,
    input wire logic [6:0] CURSOR_ADDRESS,
    input wire logic GLYPH_TARGET
);
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RST);

    // A write ends at the first edge seeing enable low; four-bit halves are left out.
    sequence s_end(s);
        !ENABLE_OR_READ_N && $past(ENABLE_OR_READ_N) && !$past(RW_OR_WRITE_N)
            && CMD_DATA_SELECT == s && BUS_WIDTH_8;
    endsequence

    property p_reset_state;
        $fell(RST) |-> BUS_WIDTH_8 && LINES_TWO && LUMINANCE == 2'h0 && INCREMENT
            && !SHIFT_ENABLE && CURSOR_ADDRESS == 7'h00 && SHIFT_OFFSET == 7'h00;
    endproperty
    property p_oe;
        DATA_OE == ($past(ENABLE_OR_READ_N) && $past(RW_OR_WRITE_N));
    endproperty
    property p_status;
        ENABLE_OR_READ_N && !$past(ENABLE_OR_READ_N) && RW_OR_WRITE_N && !CMD_DATA_SELECT
            && BUS_WIDTH_8 |=> DATA_OUT == {BUSY_FLAG_VALUE, $past(CURSOR_ADDRESS)};
    endproperty
    property p_status_still;
        DATA_OE && !CMD_DATA_SELECT |=> $stable(CURSOR_ADDRESS);
    endproperty
    property p_step;
        s_end(1'b1) ##0 !GLYPH_TARGET |=>
            CURSOR_ADDRESS == $past(CURSOR_ADDRESS) + (INCREMENT ? 7'h01 : 7'h7F);
    endproperty
    property p_shift;
        s_end(1'b1) ##0 (!GLYPH_TARGET && SHIFT_ENABLE) |=>
            SHIFT_OFFSET == $past(SHIFT_OFFSET) + (INCREMENT ? 7'h01 : 7'h7F);
    endproperty
    property p_char_set;
        s_end(1'b0) ##0 DATA_IN[7] |=> CURSOR_ADDRESS == $past(DATA_IN[6:0]) && !GLYPH_TARGET;
    endproperty
    property p_glyph_set;
        s_end(1'b0) ##0 DATA_IN[7:6] == 2'h1 |=>
            CURSOR_ADDRESS == {1'b0, $past(DATA_IN[5:0])} && GLYPH_TARGET;
    endproperty
    property p_func;
        s_end(1'b0) ##0 DATA_IN[7:5] == 3'h1 |=> BUS_WIDTH_8 == $past(DATA_IN[4])
            && LINES_TWO == $past(DATA_IN[3]) && LUMINANCE == $past(DATA_IN[1:0])
            && $stable(CURSOR_ADDRESS);
    endproperty

    a_reset_state: assert property (p_reset_state)
        else $error("Bad state after reset.");
    a_oe: assert property (p_oe) else $error("Data enable out of step.");
    a_status: assert property (p_status) else $error("Status read value wrong.");
    a_status_still: assert property (p_status_still)
        else $error("Status read moved counter.");
    a_step: assert property (p_step) else $error("Counter step wrong.");
    a_shift: assert property (p_shift) else $error("Display shift wrong.");
    a_char_set: assert property (p_char_set) else $error("Char address set wrong.");
    a_glyph_set: assert property (p_glyph_set) else $error("Glyph address set wrong.");
    a_func: assert property (p_func) else $error("Function set wrong.");
endmodule : vie_executor_asserts

//--- verification/vie_host_model.sv
// Host processor model on the read/write-plus-enable parallel pins.
// Assumes the bench calls xfer from one process only.
`timescale 1ns/10ps
module vie_host_model (
    // Clock and pins.
    input wire logic clk,
    output logic sel,
    output logic rw,
    output logic en,
    output logic [7:0] dq,
    input wire logic [7:0] din
);
    initial begin
        sel = 1'b0;
        rw = 1'b1;
        en = 1'b0;
        dq = 8'h00;
    end

    // Each level lasts two edges, one more than the device needs.
    task automatic xfer(input logic s, input logic r, input logic [7:0] d, output logic [7:0] q);
        @(posedge clk);
        sel <= s;
        rw <= r;
        dq <= d;
        en <= 1'b1;
        repeat (2) @(posedge clk);
        q = din;
        en <= 1'b0;
        @(posedge clk);
        dq <= ~d; // Released lines show junk, not the last byte.
    endtask : xfer
endmodule : vie_host_model

//--- verification/test_vie_instruction_executor.sv
// Self-checking bench of the instruction executor.
// Assumes the host model and the checker compiled before it.
`timescale 1ns/10ps
module test_vie_instruction_executor
    import vie_pkg::*;
;
    logic clock, rst, sel, rw, en, oe, bw8, two, dsp, cur, blk, inc, shen, gt;
    logic [7:0] dq, dout, csd, gsd, q;
    logic [1:0] lum;
    logic [6:0] off, cad, csa;
    logic [5:0] gsa;
    int num_errors = 0;
    int compares = 0;
    // Rows: function set byte, then width, lines and luminance expected.
    logic [11:0] rows [5] = '{12'h3CC, 12'h39D, 12'h32A, 12'h37B, 12'h2B7};

    vie_host_model host (.clk(clock), .sel(sel), .rw(rw), .en(en), .dq(dq), .din(dout));
    vie_instruction_executor DUT (.CLOCK(clock), .RST(rst), .MODE_STRAP(2'h0),
        .CMD_DATA_SELECT(sel), .RW_OR_WRITE_N(rw), .ENABLE_OR_READ_N(en), .DATA_IN(dq),
        .DATA_OUT(dout), .DATA_OE(oe), .SERIAL_STROBE_N(1'b1), .SERIAL_CLOCK(1'b0),
        .SERIAL_IN(1'b0), .SERIAL_OUT(), .SERIAL_OE(), .BUS_WIDTH_8(bw8), .LINES_TWO(two),
        .LUMINANCE(lum), .DISPLAY_ON(dsp), .CURSOR_ON(cur), .BLINK_ON(blk), .INCREMENT(inc),
        .SHIFT_ENABLE(shen), .SHIFT_OFFSET(off), .CURSOR_ADDRESS(cad), .GLYPH_TARGET(gt),
        .CHAR_SCAN_ADDR(csa), .CHAR_SCAN_DATA(csd), .GLYPH_SCAN_ADDR(gsa),
        .GLYPH_SCAN_DATA(gsd));

    // Clock at 250 MHz.
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // The extra edge lets a completed transfer's effect land.
    task automatic wr(input logic s, input logic [7:0] d);
        host.xfer(s, 1'b0, d, q);
        @(posedge clock);
    endtask : wr
    task automatic rd(input logic s);
        host.xfer(s, 1'b1, 8'h00, q);
        @(posedge clock);
    endtask : rd
    task automatic scan(input logic [6:0] a, input logic [5:0] g);
        csa <= a;
        gsa <= g;
        repeat (2) @(posedge clock);
    endtask : scan

    task automatic print_verdict;
        $display("Mismatches %0d, comparisons %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : print_verdict

    // A hang costs one mismatch; the whole run needs well under a thousand cycles.
    initial begin
        repeat (5000) @(posedge clock);
        num_errors++;
        print_verdict();
    end

    initial begin
        rst = 1'b1;
        csa = 7'h00;
        gsa = 6'h00;
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        repeat (2) @(posedge clock);
        chk({bw8, two, lum, inc, shen, dsp, cur}, 8'hC8);
        chk({blk, cad}, 8'h00);
        chk({gt, off}, 8'h00);
        scan(7'h00, 6'h00);
        chk(csd, SPACE_CODE);
        scan(7'h7F, 6'h00);
        chk(csd, SPACE_CODE);
        foreach (rows[i]) begin
            wr(1'b0, rows[i][11:4]);
            chk({4'h0, bw8, two, lum}, {4'h0, rows[i][3:0]});
        end
        wr(1'b0, 8'h30);
        wr(1'b0, 8'hC0);
        chk({7'h00, bw8}, 8'h01);
        wr(1'b0, 8'h93);
        wr(1'b1, 8'h41);
        chk({1'b0, cad}, 8'h14);
        rd(1'b0);
        chk(q, 8'h14);
        wr(1'b0, 8'h93);
        rd(1'b1);
        chk(q, 8'h41);
        chk({1'b0, cad}, 8'h14);
        wr(1'b0, 8'h7F);
        wr(1'b1, 8'h15);
        chk({gt, cad}, 8'h80);
        wr(1'b0, 8'h7F);
        rd(1'b1);
        chk(q, 8'h15);
        wr(1'b0, 8'h3C);
        scan(7'h13, 6'h3F);
        chk(csd, 8'h41);
        chk(gsd, 8'h15);
        wr(1'b0, 8'h07);
        wr(1'b0, 8'h80);
        wr(1'b1, 8'h31);
        chk({cad, 1'b0}, {7'h01, 1'b0});
        chk({1'b0, off}, 8'h01);
        wr(1'b0, 8'h05);
        wr(1'b1, 8'h32);
        chk({inc, off}, 8'h00);
        chk({1'b0, cad}, 8'h00);
        print_verdict();
    end
endmodule : test_vie_instruction_executor

bind vie_instruction_executor vie_executor_asserts u_chk (.CLOCK(CLOCK), .RST(RST),
    .CMD_DATA_SELECT(CMD_DATA_SELECT), .RW_OR_WRITE_N(RW_OR_WRITE_N),
    .ENABLE_OR_READ_N(ENABLE_OR_READ_N), .DATA_IN(DATA_IN), .DATA_OUT(DATA_OUT),
    .DATA_OE(DATA_OE), .BUS_WIDTH_8(BUS_WIDTH_8), .LINES_TWO(LINES_TWO),
    .LUMINANCE(LUMINANCE), .INCREMENT(INCREMENT), .SHIFT_ENABLE(SHIFT_ENABLE),
    .SHIFT_OFFSET(SHIFT_OFFSET), .CURSOR_ADDRESS(CURSOR_ADDRESS), .GLYPH_TARGET(GLYPH_TARGET));
